/* File: design/dcu_pkg.sv */
// Constants, field layout and types of the channel upper configuration block
package dcu_pkg;

  localparam logic [31:0] CFG_UPPER_ADDR  = 32'hB070_009C;
  localparam logic [31:0] STATE_ADDR      = 32'hB070_0F00;
  localparam logic [31:0] CFG_UPPER_RESET = 32'h0000_0004;
  localparam int          CFG_W           = 15;

  // Field positions of the upper configuration word
  localparam int DST_PORT_MSB  = 14;
  localparam int DST_PORT_LSB  = 11;
  localparam int SRC_PORT_MSB  = 10;
  localparam int SRC_PORT_LSB  = 7;
  localparam int SS_WB_BIT     = 6;
  localparam int DS_WB_BIT     = 5;
  localparam int PROT_MSB      = 4;
  localparam int PROT_LSB      = 2;
  localparam int FIFO_MODE_BIT = 1;
  localparam int FLOW_SEL_BIT  = 0;

  // Bit positions of the state word
  localparam int ST_LOCKED_BIT  = 0;
  localparam int ST_PENDING_BIT = 1;
  localparam int ST_SS_BUSY_BIT = 2;
  localparam int ST_DS_BUSY_BIT = 3;
  localparam int ST_W           = 4;

  localparam logic HPROT_DATA = 1'b1;

  typedef struct packed {
    logic [3:0] destination_handshake_port;
    logic [3:0] source_handshake_port;
    logic       source_status_writeback_enable;
    logic       destination_status_writeback_enable;
    logic [2:0] bus_protection_bits;
    logic       fifo_mode;
    logic       flow_prefetch_select;
  } dcu_cfg_t;

  localparam dcu_cfg_t CFG_RESET = dcu_cfg_t'(CFG_UPPER_RESET[CFG_W-1:0]);

  typedef enum logic [1:0] {
    FS_IDLE  = 2'b00,
    FS_READ  = 2'b01,
    FS_WRITE = 2'b11
  } dcu_fetch_state_t;

endpackage : dcu_pkg

/* File: design/dcu_status_fetch.sv */
// Status fetch and descriptor write-back sequencer for one side of the channel
`timescale 1ns/10ps
`default_nettype none
module dcu_status_fetch (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_enable,
  input  wire logic                      i_start,
  input  wire logic [31:0]               i_stat_addr,
  input  wire logic [31:0]               i_slot_addr,
  output logic                           o_rd_req,
  output logic      [31:0]               o_rd_addr,
  input  wire logic                      i_rd_valid,
  input  wire logic [31:0]               i_rd_data,
  output logic                           o_wr_req,
  output logic      [31:0]               o_wr_addr,
  input  wire logic                      i_wr_done,
  output logic      [31:0]               o_value,
  output logic                           o_busy
);
  import dcu_pkg::*;

  typedef struct packed {
    dcu_fetch_state_t state;
    logic [31:0]      rd_addr;
    logic [31:0]      wr_addr;
    logic [31:0]      value;
  } dcu_fetch_t;

  dcu_fetch_t s;
  dcu_fetch_t next_s;

  always_comb begin
    next_s = s;
    case (s.state)
      FS_IDLE: begin
        if (i_start && i_enable) begin
          next_s.state   = FS_READ;
          next_s.rd_addr = i_stat_addr;
          next_s.wr_addr = i_slot_addr;
        end
      end
      FS_READ: begin
        if (i_rd_valid) begin
          next_s.value = i_rd_data;
          next_s.state = FS_WRITE;
        end
      end
      FS_WRITE: begin
        if (i_wr_done) begin
          next_s.state = FS_IDLE;
        end
      end
      default: next_s.state = FS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s <= '{state: FS_IDLE, rd_addr: 32'h0000_0000, wr_addr: 32'h0000_0000,
             value: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  assign o_rd_req  = (s.state == FS_READ);
  assign o_rd_addr = s.rd_addr;
  assign o_wr_req  = (s.state == FS_WRITE);
  assign o_wr_addr = s.wr_addr;
  assign o_value   = s.value;
  assign o_busy    = (s.state != FS_IDLE);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_fetch_from_addr: assert property (
    (i_start && i_enable && !o_busy) |=> o_rd_req && o_rd_addr == $past(i_stat_addr))
    else $error("status fetch did not start at the status address");
  a_store_and_write: assert property (
    (o_rd_req && i_rd_valid) |=> o_wr_req && o_value == $past(i_rd_data)
      && o_wr_addr == $past(o_wr_addr))
    else $error("fetched status not stored or not written back");
  a_no_fetch_disabled: assert property (
    (!o_busy && !i_enable) |=> !o_busy)
    else $error("status fetch ran while write-back disabled");

endmodule : dcu_status_fetch
`default_nettype wire

/* File: design/dcu_chan_upper_cfg.sv */
// Channel upper configuration word with request servicing and status write-back
//
// Notes on behaviour
// - The working copy of the configuration stays frozen for every block while the channel runs.
// - Bits 14:11 pick hardware interface 0-1 for the destination, only when its select is zero.
// - Bits 10:7 pick hardware interface 0-1 for the source, only when its select is zero.
// - Bit 6 fetches source status, stores it and writes it into the descriptor slot.
// - Bit 5 fetches destination status, stores it and writes it into the descriptor slot.
// - HPROT[0] is always high since every access is a data access.
// - With bit 1 clear a request is served once one transfer of space or data is there.
// - With bit 1 set destination waits for half the FIFO of data, source for over half free.
// - In half mode the threshold is waived at burst end and at block end.
// - With destination flow control and bit 0 clear source requests go at once, prefetch on.
// - With destination flow control and bit 0 set source waits for a destination request and an empty FIFO, prefetch off.
`timescale 1ns/10ps
`default_nettype none
module dcu_chan_upper_cfg #(
  parameter int FIFO_BYTES = 16,
  parameter int NUM_HS     = 2,
  parameter int CNTW       = $clog2(FIFO_BYTES + 1)
) (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST_N,
  input  wire logic [31:0]           I_ADDR,
  input  wire logic [31:0]           I_WDATA,
  input  wire logic                  I_WR,
  input  wire logic                  I_RD,
  output logic      [31:0]           O_RDATA,
  input  wire logic                  I_CH_ENABLE,
  input  wire logic                  I_SRC_HS_SEL,
  input  wire logic                  I_DST_HS_SEL,
  input  wire logic [NUM_HS-1:0]     I_HW_REQ,
  input  wire logic                  I_SW_SRC_REQ,
  input  wire logic                  I_SW_DST_REQ,
  input  wire logic                  I_DST_IS_FLOW_CTRL,
  input  wire logic [CNTW-1:0]       I_FIFO_BYTES,
  input  wire logic [CNTW-1:0]       I_TR_BYTES,
  input  wire logic                  I_BURST_END,
  input  wire logic                  I_BLOCK_END,
  output logic                       O_SRC_REQ,
  output logic                       O_DST_REQ,
  output logic                       O_SRC_SERVICE,
  output logic                       O_DST_SERVICE,
  output logic                       O_PREFETCH_EN,
  output logic      [3:0]            O_HPROT,
  input  wire logic                  I_BLOCK_DONE,
  input  wire logic [31:0]           I_SRC_STAT_ADDR,
  input  wire logic [31:0]           I_DST_STAT_ADDR,
  input  wire logic [31:0]           I_SRC_SLOT_ADDR,
  input  wire logic [31:0]           I_DST_SLOT_ADDR,
  input  wire logic [31:0]           I_STAT_RD_DATA,
  output logic                       O_SS_RD_REQ,
  output logic      [31:0]           O_SS_RD_ADDR,
  input  wire logic                  I_SS_RD_VALID,
  output logic                       O_SS_WR_REQ,
  output logic      [31:0]           O_SS_WR_ADDR,
  input  wire logic                  I_SS_WR_DONE,
  output logic      [31:0]           O_SOURCE_STATUS_VALUE,
  output logic                       O_DS_RD_REQ,
  output logic      [31:0]           O_DS_RD_ADDR,
  input  wire logic                  I_DS_RD_VALID,
  output logic                       O_DS_WR_REQ,
  output logic      [31:0]           O_DS_WR_ADDR,
  input  wire logic                  I_DS_WR_DONE,
  output logic      [31:0]           O_DESTINATION_STATUS_VALUE
);
  import dcu_pkg::*;

  localparam logic [CNTW-1:0] DEPTH_C = CNTW'(FIFO_BYTES);
  localparam logic [CNTW-1:0] HALF_C  = CNTW'(FIFO_BYTES / 2);

  typedef struct packed {
    dcu_cfg_t    cfg;
    dcu_cfg_t    active;
    logic        locked;
    logic        dst_pending;
    logic [31:0] rdata;
  } dcu_state_t;

  dcu_state_t s;
  dcu_state_t next_s;

  logic        ss_busy;
  logic        ds_busy;
  logic        src_req;
  logic        dst_req;
  logic        src_room;
  logic        dst_data;
  logic        src_gated;
  logic [CNTW-1:0] free_bytes;

  // Request of the chosen interface, software when its select is set, else hardware; an index past the last one is idle
  function automatic logic pick_req(input logic [3:0]        port,
                                    input logic              sw_sel,
                                    input logic              sw_req,
                                    input logic [NUM_HS-1:0] hw);
    logic r;
    r = 1'b0;
    if (sw_sel) begin
      r = sw_req;
    end else begin
      for (int i = 0; i < NUM_HS; i++) begin
        if (port == 4'(i)) begin
          r = hw[i];
        end
      end
    end
    return r;
  endfunction : pick_req

  // Whether enough data or space stands in the FIFO for one request
  function automatic logic fifo_ready(input logic [CNTW-1:0] avail,
                                      input logic [CNTW-1:0] need,
                                      input logic            half_mode,
                                      input logic            waive,
                                      input logic            strict);
    logic ok;
    ok = 1'b0;
    if (!half_mode) begin
      ok = (avail >= need) && (avail != '0);
    end else if (waive) begin
      ok = (avail != '0);
    end else if (strict) begin
      ok = (avail > HALF_C);
    end else begin
      ok = (avail >= HALF_C);
    end
    return ok;
  endfunction : fifo_ready

  always_comb begin
    src_req = pick_req(s.active.source_handshake_port, I_SRC_HS_SEL,
                       I_SW_SRC_REQ, I_HW_REQ);
    dst_req = pick_req(s.active.destination_handshake_port, I_DST_HS_SEL,
                       I_SW_DST_REQ, I_HW_REQ);
    free_bytes = DEPTH_C - I_FIFO_BYTES;
    dst_data = fifo_ready(I_FIFO_BYTES, I_TR_BYTES, s.active.fifo_mode,
                          I_BURST_END || I_BLOCK_END, 1'b0);
    src_room = fifo_ready(free_bytes, I_TR_BYTES, s.active.fifo_mode,
                          I_BURST_END || I_BLOCK_END, 1'b1);
    // Holding back until the FIFO is drained keeps source data within what
    // the destination can still take before it ends the block
    src_gated = I_DST_IS_FLOW_CTRL && s.active.flow_prefetch_select &&
                !(s.dst_pending && I_FIFO_BYTES == '0);
  end

  assign O_SRC_REQ     = src_req;
  assign O_DST_REQ     = dst_req;
  assign O_DST_SERVICE = dst_req && dst_data;
  assign O_SRC_SERVICE = src_req && src_room && !src_gated;
  assign O_PREFETCH_EN = !(I_DST_IS_FLOW_CTRL && s.active.flow_prefetch_select);
  assign O_HPROT       = {s.active.bus_protection_bits, HPROT_DATA};
  assign O_RDATA       = s.rdata;

  always_comb begin
    next_s       = s;
    next_s.rdata = 32'h0000_0000;
    next_s.locked = I_CH_ENABLE;
    if (I_WR && I_ADDR == CFG_UPPER_ADDR) begin
      next_s.cfg = dcu_cfg_t'(I_WDATA[CFG_W-1:0]);
    end
    if (I_RD) begin
      case (I_ADDR)
        CFG_UPPER_ADDR: next_s.rdata = {{(32-CFG_W){1'b0}}, s.cfg};
        STATE_ADDR: begin
          next_s.rdata[ST_LOCKED_BIT]  = s.locked;
          next_s.rdata[ST_PENDING_BIT] = s.dst_pending;
          next_s.rdata[ST_SS_BUSY_BIT] = ss_busy;
          next_s.rdata[ST_DS_BUSY_BIT] = ds_busy;
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    // Copy taken only while idle, so later writes wait for the next enable
    if (!I_CH_ENABLE) begin
      next_s.active = s.cfg;
    end
    // Set wins over clear so a request in the serving cycle stays noted
    if (O_DST_SERVICE || !I_CH_ENABLE) begin
      next_s.dst_pending = 1'b0;
    end
    if (dst_req && I_CH_ENABLE) begin
      next_s.dst_pending = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      s <= '{cfg: CFG_RESET, active: CFG_RESET, locked: 1'b0, dst_pending: 1'b0,
             rdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  dcu_status_fetch u_src_status (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_enable    (s.active.source_status_writeback_enable),
    .i_start     (I_BLOCK_DONE),
    .i_stat_addr (I_SRC_STAT_ADDR),
    .i_slot_addr (I_SRC_SLOT_ADDR),
    .o_rd_req    (O_SS_RD_REQ),
    .o_rd_addr   (O_SS_RD_ADDR),
    .i_rd_valid  (I_SS_RD_VALID),
    .i_rd_data   (I_STAT_RD_DATA),
    .o_wr_req    (O_SS_WR_REQ),
    .o_wr_addr   (O_SS_WR_ADDR),
    .i_wr_done   (I_SS_WR_DONE),
    .o_value     (O_SOURCE_STATUS_VALUE),
    .o_busy      (ss_busy)
  );

  dcu_status_fetch u_dst_status (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_enable    (s.active.destination_status_writeback_enable),
    .i_start     (I_BLOCK_DONE),
    .i_stat_addr (I_DST_STAT_ADDR),
    .i_slot_addr (I_DST_SLOT_ADDR),
    .o_rd_req    (O_DS_RD_REQ),
    .o_rd_addr   (O_DS_RD_ADDR),
    .i_rd_valid  (I_DS_RD_VALID),
    .i_rd_data   (I_STAT_RD_DATA),
    .o_wr_req    (O_DS_WR_REQ),
    .o_wr_addr   (O_DS_WR_ADDR),
    .i_wr_done   (I_DS_WR_DONE),
    .o_value     (O_DESTINATION_STATUS_VALUE),
    .o_busy      (ds_busy)
  );

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_cfg_frozen_run: assert property (
    $past(I_CH_ENABLE) |-> $stable(O_HPROT) && $stable(s.active))
    else $error("working configuration changed while channel enabled");
  a_dst_port_pick: assert property (
    (!I_DST_HS_SEL && s.active.destination_handshake_port == 4'h1)
      |-> O_DST_REQ == I_HW_REQ[1])
    else $error("destination request not taken from selected interface");
  a_src_sel_ignore: assert property (
    (I_SRC_HS_SEL || s.active.source_handshake_port > 4'h1)
      |-> O_SRC_REQ == (I_SRC_HS_SEL && I_SW_SRC_REQ))
    else $error("source hardware field not ignored");
  a_prot_follows_wr: assert property (
    (I_WR && I_ADDR == CFG_UPPER_ADDR && !I_CH_ENABLE) ##1 !I_CH_ENABLE && !I_WR
      |=> O_HPROT[3:1] == $past(I_WDATA[PROT_MSB:PROT_LSB], 2))
    else $error("protection bits do not follow the written field");
  a_hprot_data_hi: assert property (
    O_HPROT[0] && $past(O_HPROT[0]))
    else $error("HPROT[0] not high");
  a_single_serve: assert property (
    (!s.active.fifo_mode && O_DST_REQ && I_FIFO_BYTES >= I_TR_BYTES
      && I_FIFO_BYTES != '0) |-> O_DST_SERVICE)
    else $error("single transfer not served");
  a_half_wait_dst: assert property (
    (s.active.fifo_mode && !I_BURST_END && !I_BLOCK_END && I_FIFO_BYTES < HALF_C)
      |-> !O_DST_SERVICE)
    else $error("destination served below half threshold");
  a_half_waive_end: assert property (
    (s.active.fifo_mode && O_DST_REQ && I_BLOCK_END && I_FIFO_BYTES != '0)
      |-> O_DST_SERVICE)
    else $error("threshold not waived at block end");
  a_prefetch_free: assert property (
    (I_DST_IS_FLOW_CTRL && !s.active.flow_prefetch_select && O_SRC_REQ
      && !s.active.fifo_mode && free_bytes >= I_TR_BYTES && free_bytes != '0)
      |-> O_SRC_SERVICE && O_PREFETCH_EN)
    else $error("source not served at once in prefetch mode");
  a_src_waits_dst: assert property (
    (I_DST_IS_FLOW_CTRL && s.active.flow_prefetch_select && !s.dst_pending)
      |-> !O_SRC_SERVICE && !O_PREFETCH_EN)
    else $error("source served without destination request");
  a_reserved_read: assert property (
    (I_RD && I_ADDR == CFG_UPPER_ADDR)
      |=> O_RDATA[31:CFG_W] == '0 && O_RDATA[CFG_W-1:0] == $past(s.cfg))
    else $error("configuration readback wrong");

  a_src_port_pick: assert property (
    (!I_SRC_HS_SEL && s.active.source_handshake_port == 4'h0)
      |-> O_SRC_REQ == I_HW_REQ[0])
    else $error("source request not taken from selected interface");

  a_dst_sel_ignore: assert property (
    (I_DST_HS_SEL || s.active.destination_handshake_port > 4'h1)
      |-> O_DST_REQ == (I_DST_HS_SEL && I_SW_DST_REQ))
    else $error("destination hardware field not ignored");

  a_single_wait: assert property (
    (!s.active.fifo_mode && I_FIFO_BYTES < I_TR_BYTES) |-> !O_DST_SERVICE)
    else $error("destination served without one transfer of data");

  a_half_serve_dst: assert property (
    (s.active.fifo_mode && O_DST_REQ && I_FIFO_BYTES >= HALF_C && I_FIFO_BYTES != '0)
      |-> O_DST_SERVICE)
    else $error("destination not served at half threshold");

  a_half_wait_src: assert property (
    (s.active.fifo_mode && !I_BURST_END && !I_BLOCK_END && free_bytes <= HALF_C)
      |-> !O_SRC_SERVICE)
    else $error("source served without more than half free");

  a_waive_burst_src: assert property (
    (s.active.fifo_mode && O_SRC_REQ && !src_gated && I_BURST_END && free_bytes != '0)
      |-> O_SRC_SERVICE)
    else $error("threshold not waived at burst end");

  a_prefetch_on: assert property (
    (!I_DST_IS_FLOW_CTRL || !s.active.flow_prefetch_select) |-> O_PREFETCH_EN)
    else $error("prefetch off outside destination flow mode");

  a_pending_set: assert property (
    (O_DST_REQ && I_CH_ENABLE) |=> s.dst_pending)
    else $error("destination request not noted");

  a_pending_clear: assert property (
    !I_CH_ENABLE |=> !s.dst_pending)
    else $error("destination request kept while disabled");

  a_cfg_copy_idle: assert property (
    !I_CH_ENABLE |=> s.active == $past(s.cfg))
    else $error("working configuration not copied while idle");

  a_cfg_write_lands: assert property (
    (I_WR && I_ADDR == CFG_UPPER_ADDR) |=> s.cfg == $past(I_WDATA[CFG_W-1:0]))
    else $error("configuration write not stored");

  a_rdata_idle: assert property (
    !I_RD |=> O_RDATA == 32'h0000_0000)
    else $error("read data not zero outside a read");

  a_state_locked: assert property (
    (I_RD && I_ADDR == STATE_ADDR) |=> O_RDATA[ST_LOCKED_BIT] == $past(s.locked))
    else $error("state word does not show the enable");

  c_half_src_serve: cover property (s.active.fifo_mode && O_SRC_SERVICE);
  c_waive_burst:    cover property (s.active.fifo_mode && I_BURST_END && O_DST_SERVICE);
  c_flow_src_serve: cover property (s.active.flow_prefetch_select && I_DST_IS_FLOW_CTRL
                                    && O_SRC_SERVICE);
  c_status_wb:      cover property (O_SS_WR_REQ && I_SS_WR_DONE);
  c_pending_serve:  cover property (s.dst_pending && I_DST_IS_FLOW_CTRL && O_SRC_SERVICE);

endmodule : dcu_chan_upper_cfg
`default_nettype wire

/* File: dv/dcu_mem_model.sv */
// Status memory model answering fetch reads and descriptor write-backs
`timescale 1ns/10ps
`default_nettype none
module dcu_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_slow,
  input  wire logic        i_ss_rd_req,
  input  wire logic [31:0] i_ss_rd_addr,
  input  wire logic        i_ss_wr_req,
  input  wire logic        i_ds_rd_req,
  input  wire logic [31:0] i_ds_rd_addr,
  input  wire logic        i_ds_wr_req,
  output logic             o_ss_rd_valid,
  output logic             o_ss_wr_done,
  output logic             o_ds_rd_valid,
  output logic             o_ds_wr_done,
  output logic      [31:0] o_rd_data
);
  localparam logic [31:0] KEY = 32'hA5A5_0000;
  int wait_cnt;
  logic pulse;
  initial o_rd_data = 32'h0000_0000;
  assign pulse = o_ss_rd_valid | o_ss_wr_done | o_ds_rd_valid | o_ds_wr_done;
  always @(posedge i_clk) begin
    o_ss_rd_valid <= 1'b0;
    o_ss_wr_done  <= 1'b0;
    o_ds_rd_valid <= 1'b0;
    o_ds_wr_done  <= 1'b0;
    // Stale data flips every cycle so it never passes for an answer
    o_rd_data <= ~o_rd_data;
    if (!i_rst_n) begin
      wait_cnt <= 0;
    end else if (!pulse && (i_ss_rd_req | i_ss_wr_req | i_ds_rd_req | i_ds_wr_req)) begin
      if (wait_cnt < (i_slow ? 4 : 0)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        // One answer at a time, source side first
        if (i_ss_rd_req) begin
          o_ss_rd_valid <= 1'b1;
          o_rd_data     <= i_ss_rd_addr ^ KEY;
        end else if (i_ss_wr_req) begin
          o_ss_wr_done <= 1'b1;
        end else if (i_ds_rd_req) begin
          o_ds_rd_valid <= 1'b1;
          o_rd_data     <= i_ds_rd_addr ^ KEY;
        end else begin
          o_ds_wr_done <= 1'b1;
        end
      end
    end
  end
endmodule : dcu_mem_model
`default_nettype wire

/* File: dv/dcu_chan_upper_cfg_bench.sv */
// Self-checking bench of the channel upper configuration block
`timescale 1ns/10ps
`default_nettype none
module dcu_chan_upper_cfg_bench;
  import dcu_pkg::*;
  localparam int FB = 16;
  localparam logic [31:0] KEY = 32'hA5A5_0000;
  logic clk, rst_n, wr, rd, en, ssel, dsel, swsrc, swdst, dflow, bend, kend, bdone, slow;
  logic [31:0] addr, wdata, rdata, saddr, daddr, sslot, dslot, stdata, v, d;
  logic [1:0]  hw;
  logic [4:0]  fifo, tr;
  logic srq, drq, ssv, dsv, pf, ssrr, sswr, dsrr, dswr, ssrv, sswd, dsrv, dswd;
  logic [3:0]  hprot;
  logic [31:0] ssra, sswa, dsra, dswa, ssval, dsval;
  int mismatches, checks_done, p, q;

  dcu_chan_upper_cfg #(.FIFO_BYTES(FB), .NUM_HS(2)) uut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_CH_ENABLE(en), .I_SRC_HS_SEL(ssel), .I_DST_HS_SEL(dsel),
    .I_HW_REQ(hw), .I_SW_SRC_REQ(swsrc), .I_SW_DST_REQ(swdst), .I_DST_IS_FLOW_CTRL(dflow),
    .I_FIFO_BYTES(fifo), .I_TR_BYTES(tr), .I_BURST_END(bend), .I_BLOCK_END(kend),
    .O_SRC_REQ(srq), .O_DST_REQ(drq), .O_SRC_SERVICE(ssv), .O_DST_SERVICE(dsv),
    .O_PREFETCH_EN(pf), .O_HPROT(hprot), .I_BLOCK_DONE(bdone), .I_SRC_STAT_ADDR(saddr),
    .I_DST_STAT_ADDR(daddr), .I_SRC_SLOT_ADDR(sslot), .I_DST_SLOT_ADDR(dslot),
    .I_STAT_RD_DATA(stdata), .O_SS_RD_REQ(ssrr), .O_SS_RD_ADDR(ssra), .I_SS_RD_VALID(ssrv),
    .O_SS_WR_REQ(sswr), .O_SS_WR_ADDR(sswa), .I_SS_WR_DONE(sswd),
    .O_SOURCE_STATUS_VALUE(ssval), .O_DS_RD_REQ(dsrr), .O_DS_RD_ADDR(dsra),
    .I_DS_RD_VALID(dsrv), .O_DS_WR_REQ(dswr), .O_DS_WR_ADDR(dswa), .I_DS_WR_DONE(dswd),
    .O_DESTINATION_STATUS_VALUE(dsval));

  dcu_mem_model mem (
    .i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_ss_rd_req(ssrr), .i_ss_rd_addr(ssra),
    .i_ss_wr_req(sswr), .i_ds_rd_req(dsrr), .i_ds_rd_addr(dsra), .i_ds_wr_req(dswr),
    .o_ss_rd_valid(ssrv), .o_ss_wr_done(sswd), .o_ds_rd_valid(dsrv), .o_ds_wr_done(dswd),
    .o_rd_data(stdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wreg(input logic [31:0] a, input logic [31:0] dt);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= dt;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [31:0] a, output logic [31:0] dt);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    dt = rdata;
  endtask : rreg

  // Word is written with the channel off, then the channel is turned on
  task automatic setcfg(input logic [31:0] dt);
    @(posedge clk);
    en <= 1'b0;
    wreg(CFG_UPPER_ADDR, dt);
    repeat (2) @(posedge clk);
    en <= 1'b1;
  endtask : setcfg

  function automatic logic svc(input int av, input int t, input logic half, input logic waive,
                               input logic dst);
    if (half && !waive) return dst ? (av >= FB / 2) : (av > FB / 2);
    return (av != 0) && (half || av >= t);
  endfunction : svc

  task automatic fetch(input logic sl);
    @(posedge clk);
    slow  <= sl;
    saddr <= $urandom & 32'h0FFF_FFFC;
    daddr <= $urandom & 32'h0FFF_FFFC;
    @(posedge clk);
    bdone <= 1'b1;
    @(posedge clk);
    bdone <= 1'b0;
    repeat (60) begin
      @(negedge clk);
      if (ssrr === 1'b1) chk(ssra, saddr);
      if (sswr === 1'b1) chk(sswa, sslot);
      if (dsrr === 1'b1) chk(dsra, daddr);
      if (dswr === 1'b1) chk(dswa, dslot);
    end
    chk(ssval, saddr ^ KEY);
    chk(dsval, daddr ^ KEY);
  endtask : fetch

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    {wr, rd, en, ssel, dsel, swsrc, swdst, dflow, bend, kend, bdone, slow} = '0;
    addr = '0; wdata = '0; hw = '0; fifo = '0; tr = 5'h01;
    saddr = 32'h0000_1000; daddr = 32'h0000_2000;
    sslot = 32'h0000_3000; dslot = 32'h0000_4000;
    rst_n = 1'b0; mismatches = 0; checks_done = 0;
    v = $urandom(32'h9068);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rreg(CFG_UPPER_ADDR, v);
    chk(v, CFG_UPPER_RESET);
    chk(hprot, 4'b0011);
    rreg(32'hB070_0098, v);
    chk(v, 32'h0000_0000);
    $display("test reset done");
    repeat (8) begin
      d = $urandom;
      wreg(CFG_UPPER_ADDR, d);
      @(posedge clk);
      @(negedge clk);
      chk(hprot, {d[4:2], 1'b1});
      rreg(CFG_UPPER_ADDR, v);
      chk(v, {17'h0_0000, d[14:0]});
    end
    $display("test register done");
    setcfg(32'h0000_0010);
    wreg(CFG_UPPER_ADDR, 32'h0000_000C);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(hprot, 4'b1001);
    rreg(CFG_UPPER_ADDR, v);
    chk(v, 32'h0000_000C);
    @(posedge clk);
    en <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(hprot, 4'b0111);
    $display("test freeze done");
    for (p = 0; p < 3; p++) begin
      q = p ^ 1;
      setcfg((p << 11) | (q << 7));
      for (int i = 0; i < 8; i++) begin
        @(posedge clk);
        {hw, swsrc, swdst} <= 4'($urandom);
        ssel <= i[2]; dsel <= i[2];
        @(negedge clk);
        chk(srq, ssel ? swsrc : (q < 2 ? hw[q] : 1'b0));
        chk(drq, dsel ? swdst : (p < 2 ? hw[p] : 1'b0));
      end
    end
    $display("test handshake done");
    @(posedge clk);
    ssel <= 1'b1; dsel <= 1'b1; swsrc <= 1'b1; swdst <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      setcfg(m << 1);
      for (int i = 0; i < 16; i++) begin
        @(posedge clk);
        fifo <= (i == 0) ? 5'h08 : (i == 1) ? 5'h00 : 5'($urandom % 17);
        tr   <= 5'(1 << ($urandom % 3));
        bend <= ($urandom % 4) == 0;
        kend <= ($urandom % 4) == 0;
        @(negedge clk);
        chk(ssv, svc(FB - fifo, tr, m[0], bend | kend, 1'b0));
        chk(dsv, svc(fifo, tr, m[0], bend | kend, 1'b1));
      end
    end
    $display("test threshold done");
    @(posedge clk);
    {bend, kend, swdst} <= 3'b000;
    fifo <= 5'h00; tr <= 5'h01; dflow <= 1'b1;
    setcfg(32'h0000_0000);
    @(negedge clk);
    chk(pf, 1'b1);
    chk(ssv, 1'b1);
    setcfg(32'h0000_0001);
    @(negedge clk);
    chk(pf, 1'b0);
    chk(ssv, 1'b0);
    @(posedge clk);
    swdst <= 1'b1;
    @(posedge clk);
    swdst <= 1'b0;
    @(negedge clk);
    chk(ssv, 1'b1);
    @(posedge clk);
    fifo <= 5'h04;
    @(negedge clk);
    chk(ssv, 1'b0);
    rreg(STATE_ADDR, v);
    chk(v, 32'h0000_0003);
    $display("test flow done");
    @(posedge clk);
    dflow <= 1'b0; fifo <= 5'h00;
    setcfg(32'h0000_0060);
    fetch(1'b0);
    fetch(1'b1);
    setcfg(32'h0000_0000);
    @(posedge clk);
    bdone <= 1'b1;
    @(posedge clk);
    bdone <= 1'b0;
    repeat (6) begin
      @(negedge clk);
      chk({ssrr, dsrr}, 2'b00);
    end
    $display("test status done");
    wrap_up();
  end
endmodule : dcu_chan_upper_cfg_bench
`default_nettype wire
